// File: inc/dnc_params.svh
// constants for the dac nonvolatile control block
`ifndef DNC_PARAMS_SVH
`define DNC_PARAMS_SVH

// factory contents of the nonvolatile store: normal mode, mid-scale code
`define DNC_FACTORY_PD      2'h0
`define DNC_FACTORY_CODE    12'h800

// command type codes (bit2, bit1, bit0); the fast code gives bit2 and bit1 only
`define DNC_CMD_DAC         3'h2
`define DNC_CMD_NV          3'h3
`define DNC_CMD_FAST_HI     2'h0

// power-down select codes
`define DNC_PD_NORMAL       2'h0
`define DNC_PD_LOAD_1K      2'h1
`define DNC_PD_LOAD_100K    2'h2
`define DNC_PD_LOAD_500K    2'h3

// length of a nonvolatile write in enabled core clock cycles
`define DNC_NV_WRITE_CYCLES 1024

`endif

// File: inc/dnc_pkg.sv
// types shared by the dac nonvolatile control block
package dnc_pkg;

   typedef logic [11:0] dnc_code_t;
   typedef logic [1:0]  dnc_pd_t;
   typedef logic [2:0]  dnc_cmd_t;

   typedef enum logic [1:0] {
      ST_LOAD,
      ST_IDLE,
      ST_NVWR
   } dnc_state_t;

endpackage

// File: src/dnc_top.sv
// dac control with nonvolatile store, restore on reset and power-down decode
`timescale 1ns/100ps
`include "dnc_params.svh"

module dnc_top
   import dnc_pkg::*;
#(
   parameter int unsigned NV_WRITE_CYCLES = `DNC_NV_WRITE_CYCLES
) (
   input  wire logic      i_core_clk,
   input  wire logic      i_nrst,
   input  wire logic      i_ce,
   input  wire logic      i_link_clk,
   input  wire logic      i_link_cmd_valid,
   input  wire dnc_cmd_t  i_link_cmd_type,
   input  wire dnc_pd_t   i_link_pd,
   input  wire dnc_code_t i_link_code,
   input  wire logic      i_link_gc_reset,
   input  wire logic      i_link_gc_wakeup,
   output logic           o_link_cmd_dropped,
   output dnc_code_t      o_dac_code,
   output logic           o_power_down_select_high,
   output logic           o_power_down_select_low,
   output logic           o_amp_enable,
   output logic           o_load_1k,
   output logic           o_load_100k,
   output logic           o_load_500k,
   output logic           o_nv_write_ready_flag,
   output dnc_pd_t        o_nv_pd,
   output dnc_code_t      o_nv_code,
   output logic           o_cmd_ignored
);

   localparam int CW = $clog2(NV_WRITE_CYCLES + 1);
   // ----------------------------------------------------------------
   // link domain
   // ----------------------------------------------------------------
   logic      lrst_s1_q;
   logic      lrst_s2_q;
   logic      req_q;
   logic      ack_s1_q;
   logic      ack_s2_q;
   logic      ack_q;
   logic      gcr_tgl_q;
   logic      gcw_tgl_q;
   dnc_cmd_t  hold_type_q;
   dnc_pd_t   hold_pd_q;
   dnc_code_t hold_code_q;
   logic      link_free;

   // link reset released on the link clock so the first frame sees clean state
   always_ff @(posedge i_link_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         lrst_s1_q <= 1'b0;
         lrst_s2_q <= 1'b0;
      end else begin
         lrst_s1_q <= 1'b1;
         lrst_s2_q <= lrst_s1_q;
      end
   end

   // acknowledge toggle coming back from the core
   always_ff @(posedge i_link_clk or negedge lrst_s2_q) begin
      if (!lrst_s2_q) begin
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
      end else begin
         ack_s1_q <= ack_q;
         ack_s2_q <= ack_s1_q;
      end
   end
   assign link_free = (req_q == ack_s2_q);
   // hold a finished command word; it stays frozen until the core acknowledges
   always_ff @(posedge i_link_clk or negedge lrst_s2_q) begin
      if (!lrst_s2_q) begin
         req_q              <= 1'b0;
         hold_type_q        <= 3'h0;
         hold_pd_q          <= 2'h0;
         hold_code_q        <= 12'h000;
         o_link_cmd_dropped <= 1'b0;
      end else begin
         o_link_cmd_dropped <= i_link_cmd_valid && !link_free;
         if (i_link_cmd_valid && link_free) begin
            req_q       <= !req_q;
            hold_type_q <= i_link_cmd_type;
            hold_pd_q   <= i_link_pd;
            hold_code_q <= i_link_code;
         end
      end
   end

   // general call events are single toggles, no payload to protect
   always_ff @(posedge i_link_clk or negedge lrst_s2_q) begin
      if (!lrst_s2_q) begin
         gcr_tgl_q <= 1'b0;
         gcw_tgl_q <= 1'b0;
      end else begin
         if (i_link_gc_reset) begin
            gcr_tgl_q <= !gcr_tgl_q;
         end
         if (i_link_gc_wakeup) begin
            gcw_tgl_q <= !gcw_tgl_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // core domain crossings
   // ----------------------------------------------------------------
   logic       rst_s1_q;
   logic       rst_s2_q;
   logic       rst_n;
   logic       req_s1_q;
   logic       req_s2_q;
   logic [2:0] gcr_sync_q;
   logic [2:0] gcw_sync_q;
   logic       cmd_evt;
   logic       gc_rst_evt;
   logic       wake_evt;

   // power-on reset: asserted at once, released through two flops
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   assign rst_n = rst_s2_q;
   // toggles synchronised; the third stage only feeds edge detection
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_s1_q   <= 1'b0;
         req_s2_q   <= 1'b0;
         gcr_sync_q <= 3'h0;
         gcw_sync_q <= 3'h0;
      end else if (i_ce) begin
         req_s1_q   <= req_q;
         req_s2_q   <= req_s1_q;
         gcr_sync_q <= {gcr_sync_q[1:0], gcr_tgl_q};
         gcw_sync_q <= {gcw_sync_q[1:0], gcw_tgl_q};
      end
   end
   assign cmd_evt    = (req_s2_q != ack_q);
   assign gc_rst_evt = gcr_sync_q[2] ^ gcr_sync_q[1];
   assign wake_evt   = gcw_sync_q[2] ^ gcw_sync_q[1];

   // every command is acknowledged, even one that is then discarded
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else if (i_ce && cmd_evt) begin
         ack_q <= req_s2_q;
      end
   end

   // ----------------------------------------------------------------
   // command decode and sequencing
   // ----------------------------------------------------------------
   dnc_state_t      state_q;
   logic [CW-1:0]   wr_cnt_q;
   logic            take_cmd;
   logic            cmd_fast;
   logic            cmd_dac;
   logic            cmd_nv;
   logic            cmd_load;
   logic            wr_done;
   dnc_pd_t         dac_pd_q;
   dnc_pd_t         nv_pd_q;
   dnc_code_t       nv_code_q;
   dnc_pd_t         stage_pd_q;
   dnc_code_t       stage_code_q;

   // payload is stable here: the link holds it until ack_q moves
   assign take_cmd = cmd_evt && (state_q == ST_IDLE);
   assign cmd_fast = (hold_type_q[2:1] == `DNC_CMD_FAST_HI);
   assign cmd_dac  = (hold_type_q == `DNC_CMD_DAC);
   assign cmd_nv   = (hold_type_q == `DNC_CMD_NV);
   assign cmd_load = take_cmd && (cmd_fast || cmd_dac || cmd_nv);
   assign wr_done  = (state_q == ST_NVWR) && (wr_cnt_q == CW'(NV_WRITE_CYCLES - 1));

   // sequencer: restore after power-on, idle, timed store write
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q  <= ST_LOAD;
         wr_cnt_q <= '0;
      end else if (i_ce) begin
         unique case (state_q)
            ST_LOAD: begin
               state_q <= ST_IDLE;
            end
            ST_IDLE: begin
               if (take_cmd && cmd_nv) begin
                  state_q  <= ST_NVWR;
                  wr_cnt_q <= '0;
               end
            end
            ST_NVWR: begin
               wr_cnt_q <= wr_cnt_q + CW'(1);
               if (wr_done) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // ready flag low for the whole store write
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_nv_write_ready_flag <= 1'b1;
      end else if (i_ce) begin
         if (take_cmd && cmd_nv) begin
            o_nv_write_ready_flag <= 1'b0;
         end else if (wr_done) begin
            o_nv_write_ready_flag <= 1'b1;
         end
      end
   end

   // discarded commands: busy or reserved type
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_cmd_ignored <= 1'b0;
      end else if (i_ce) begin
         o_cmd_ignored <= cmd_evt && !cmd_load;
      end
   end

   // ----------------------------------------------------------------
   // dac register
   // ----------------------------------------------------------------
   // reset reload wins over a command and over a wake-up; otherwise wake-up forces normal mode last
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_dac_code <= 12'h000;
         dac_pd_q   <= `DNC_PD_NORMAL;
      end else if (i_ce) begin
         if (state_q == ST_LOAD || gc_rst_evt) begin
            o_dac_code <= nv_code_q;
            dac_pd_q   <= nv_pd_q;
         end else begin
            if (cmd_load) begin
               o_dac_code <= hold_code_q;
               dac_pd_q   <= hold_pd_q;
            end
            if (wake_evt) begin
               dac_pd_q <= `DNC_PD_NORMAL;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // nonvolatile store
   // ----------------------------------------------------------------
   // store contents model a fresh part at power-on; a real cell keeps them
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         nv_pd_q      <= `DNC_FACTORY_PD;
         nv_code_q    <= `DNC_FACTORY_CODE;
         stage_pd_q   <= 2'h0;
         stage_code_q <= 12'h000;
      end else if (i_ce) begin
         if (take_cmd && cmd_nv) begin
            stage_pd_q   <= hold_pd_q;
            stage_code_q <= hold_code_q;
         end
         if (wr_done) begin
            nv_pd_q   <= stage_pd_q;
            nv_code_q <= stage_code_q;
         end
      end
   end
   assign o_nv_pd   = nv_pd_q;
   assign o_nv_code = nv_code_q;

   // ----------------------------------------------------------------
   // output stage control
   // ----------------------------------------------------------------
   // registered decode; the command path above never depends on the mode
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_power_down_select_high <= 1'b0;
         o_power_down_select_low  <= 1'b0;
         o_amp_enable             <= 1'b0;
         o_load_1k                <= 1'b0;
         o_load_100k              <= 1'b0;
         o_load_500k              <= 1'b0;
      end else if (i_ce) begin
         o_power_down_select_high <= dac_pd_q[1];
         o_power_down_select_low  <= dac_pd_q[0];
         o_amp_enable             <= (dac_pd_q == `DNC_PD_NORMAL);
         o_load_1k                <= (dac_pd_q == `DNC_PD_LOAD_1K);
         o_load_100k              <= (dac_pd_q == `DNC_PD_LOAD_100K);
         o_load_500k              <= (dac_pd_q == `DNC_PD_LOAD_500K);
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   int unsigned busy_cnt_q;

   // counts cycles spent busy for the write length check
   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_cnt_q <= 0;
      end else if (i_ce) begin
         busy_cnt_q <= o_nv_write_ready_flag ? 0 : busy_cnt_q + 1;
      end
   end

   power_up_load_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      (state_q == ST_LOAD && i_ce) |=> (o_dac_code == $past(nv_code_q) && state_q == ST_IDLE))
      else $error("dac register not restored after power-on");
   gc_reset_load_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      (gc_rst_evt && i_ce) |=> (o_dac_code == $past(nv_code_q) && dac_pd_q == $past(nv_pd_q)))
      else $error("general call reset did not reload dac register");
   busy_flag_low_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      (state_q == ST_NVWR) |-> !o_nv_write_ready_flag)
      else $error("ready flag high during store write");
   write_length_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      $rose(o_nv_write_ready_flag) |-> (busy_cnt_q == NV_WRITE_CYCLES))
      else $error("store write length wrong");
   busy_drop_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      (cmd_evt && i_ce && state_q == ST_NVWR && !gc_rst_evt) |=> $stable(o_dac_code))
      else $error("command taken while busy");
   reserved_drop_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      (take_cmd && i_ce && hold_type_q[2] && !gc_rst_evt) |=> ($stable(o_dac_code) && o_cmd_ignored))
      else $error("reserved command changed dac register");
   fast_no_store_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      (take_cmd && i_ce && (cmd_fast || cmd_dac)) |=> ($stable(nv_code_q) ##1 o_nv_write_ready_flag))
      else $error("register write disturbed the store");
   nv_commit_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      (take_cmd && i_ce && cmd_nv) |=> (!o_nv_write_ready_flag && stage_code_q == $past(hold_code_q)))
      else $error("store write did not start");
   wake_normal_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      (wake_evt && i_ce && !gc_rst_evt && state_q != ST_LOAD) |=> (dac_pd_q == `DNC_PD_NORMAL)
      ##1 (o_amp_enable || !$past(i_ce)))
      else $error("wake-up did not restore normal mode");
   pd_decode_a: assert property (@(posedge i_core_clk) disable iff (!rst_n)
      ($past(i_ce) && $past(rst_n)) |-> (o_amp_enable == ($past(dac_pd_q) == 2'h0)
      && o_load_500k == ($past(dac_pd_q) == 2'h3)))
      else $error("power-down decode mismatch");

endmodule

// File: testbench/dnc_link_master.sv
// link-side master model: whole write words and general calls
`timescale 1ns/100ps
module dnc_link_master
   import dnc_pkg::*;
(
   input  wire logic i_link_clk,
   output logic      o_valid,
   output dnc_cmd_t  o_type,
   output dnc_pd_t   o_pd,
   output dnc_code_t o_code,
   output logic      o_gc_reset,
   output logic      o_gc_wakeup
);
   // idle lines at time zero
   initial begin
      o_valid = 1'b0;
      o_type = 3'h4;
      o_pd = 2'h0;
      o_code = 12'h000;
      o_gc_reset = 1'b0;
      o_gc_wakeup = 1'b0;
   end

   // one whole word per valid; afterwards the word lines show its inverse,
   // so a late sample of a released word is caught rather than lucky
   task automatic send(input dnc_cmd_t t, input dnc_pd_t p, input dnc_code_t c);
      @(posedge i_link_clk);
      #1;
      o_valid = 1'b1;
      o_type = t;
      o_pd = p;
      o_code = c;
      @(posedge i_link_clk);
      #1;
      o_valid = 1'b0;
      o_type = ~t;
      o_pd = ~p;
      o_code = ~c;
      repeat (5) @(posedge i_link_clk); // let the word be acknowledged
   endtask

   // one-cycle general call pulse, reset or wake-up
   task automatic gcall(input logic wake);
      @(posedge i_link_clk);
      #1;
      o_gc_reset = ~wake;
      o_gc_wakeup = wake;
      @(posedge i_link_clk);
      #1;
      o_gc_reset = 1'b0;
      o_gc_wakeup = 1'b0;
      repeat (5) @(posedge i_link_clk);
   endtask
endmodule

// File: testbench/dnc_top_tb.sv
// self-checking bench for the dac nonvolatile control block
`timescale 1ns/100ps
`include "dnc_params.svh"
`define CHK(nm, e, g) begin num_checks++; if ((e) !== (g)) begin n_errors++; \
$display("unexpected %s: expected %h seen %h", nm, e, g); end end
module dnc_top_tb
   import dnc_pkg::*;
;
   localparam int NVC = 200;
   logic        clk = 0, lclk = 0, nrst = 0, ce = 1, jit = 0, ign_q = 0;
   logic        vld, gcr, gcw, drp, ign, amp, l1k, l100k, l500k, rdy, pdh, pdl;
   dnc_cmd_t    typ;
   dnc_pd_t     pd, nvpd;
   dnc_code_t   code, dac, nvcode, seen, c;
   logic [13:0] q[$];
   int          n_errors = 0, num_checks = 0, seed = 12, n_ign = 0, n_drop = 0, n_busy = 0;

   // ---------------------------------------------
   // clocks, stimulus and instances
   // ---------------------------------------------
   always #2 clk = ~clk;
   always #15 lclk = ~lclk; // 30 ns, its rising edges never meet core edges
   // clock enable jitters only while a store write runs
   always @(negedge clk) ce <= ~jit | 1'($random(seed));

   dnc_link_master u_host (.i_link_clk(lclk), .o_valid(vld), .o_type(typ), .o_pd(pd), .o_code(code),
                           .o_gc_reset(gcr), .o_gc_wakeup(gcw));
   dnc_top #(.NV_WRITE_CYCLES(NVC)) u_dut (
      .i_core_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_link_clk(lclk), .i_link_cmd_valid(vld),
      .i_link_cmd_type(typ), .i_link_pd(pd), .i_link_code(code), .i_link_gc_reset(gcr),
      .i_link_gc_wakeup(gcw), .o_link_cmd_dropped(drp), .o_dac_code(dac),
      .o_power_down_select_high(pdh), .o_power_down_select_low(pdl), .o_amp_enable(amp),
      .o_load_1k(l1k), .o_load_100k(l100k), .o_load_500k(l500k), .o_nv_write_ready_flag(rdy),
      .o_nv_pd(nvpd), .o_nv_code(nvcode), .o_cmd_ignored(ign));

   // event counters: discards, busy cycles, link drops
   always @(posedge clk) begin
      ign_q <= ign;
      if (ign && !ign_q) n_ign++;
      if (!rdy && ce) n_busy++;
   end
   always @(posedge lclk) if (drp) n_drop++;

   // scoreboard: each new dac code takes the oldest note; a change with
   // no note pending means a discarded write got through
   always @(posedge clk) begin : mon
      logic [13:0] e;
      if (dac !== seen) begin
         seen = dac;
         if (nrst) begin
            if (q.size() == 0) `CHK("dac_spurious", 1'b0, 1'b1)
            else begin
               e = q.pop_front();
               repeat (2) @(posedge clk); // mode outputs trail the code
               `CHK("dac_code", e[11:0], dac)
               `CHK("pd_sel", e[13:12], {pdh, pdl})
               `CHK("amp_en", e[13:12] == 2'h0, amp)
               `CHK("loads", {e[13:12] == 2'h3, e[13:12] == 2'h2, e[13:12] == 2'h1}, {l500k, l100k, l1k})
            end
         end
      end
   end

   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic wait_q();
      for (int k = 0; k < 500 && q.size() != 0; k++) @(posedge clk);
      repeat (6) @(posedge clk);
      if (q.size() != 0) begin
         n_errors++;
         $display("unexpected queue: expected 0 seen %0d", q.size());
         wrap_up();
      end
   endtask

   task automatic wait_rdy(input logic lvl);
      for (int k = 0; k < 3000 && rdy !== lvl; k++) @(posedge clk);
      if (rdy !== lvl) begin
         n_errors++;
         $display("unexpected ready: expected %b seen %b", lvl, rdy);
         wrap_up();
      end
   endtask

   // random code that always differs from the current one
   task automatic fresh();
      c = 12'($random(seed));
      c[0] = ~dac[0];
   endtask

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      q.push_back({`DNC_FACTORY_PD, `DNC_FACTORY_CODE});
      repeat (16) @(negedge clk); // long enough for two link edges as well
      nrst = 1;
      wait_q();
      `CHK("nv_store", {`DNC_FACTORY_PD, `DNC_FACTORY_CODE}, {nvpd, nvcode})
      u_host.gcall(1'b0);
      repeat (10) @(posedge clk);
      `CHK("gc_reload", `DNC_FACTORY_CODE, dac)
      $display("test power_up done");
      // every mode with fast register writes, modes 1 and 2 also with dac register writes, also writes while powered down
      for (int i = 0; i < 8; i++) begin
         fresh();
         q.push_back({2'(i), c});
         u_host.send(3'(i % 3), 2'(i), c);
         wait_q();
      end
      $display("test modes done");
      u_host.gcall(1'b1);
      repeat (10) @(posedge clk);
      `CHK("wake_amp", 1'b1, amp)
      `CHK("wake_code", c, dac)
      for (int t = 4; t < 8; t++) u_host.send(3'(t), 2'h1, ~dac);
      repeat (20) @(posedge clk);
      `CHK("reserved_ign", 4, n_ign)
      $display("test wake_reserved done");
      fresh();
      q.push_back({2'h2, c});
      n_busy = 0;
      u_host.send(`DNC_CMD_NV, 2'h2, c);
      jit = 1;
      u_host.send(`DNC_CMD_DAC, 2'h0, ~c);
      wait_rdy(1'b1);
      jit = 0;
      `CHK("busy_len", NVC, n_busy)
      `CHK("busy_ign", 5, n_ign)
      `CHK("nv_word", {2'h2, c}, {nvpd, nvcode})
      wait_q();
      q.push_back({2'h1, ~c});
      u_host.send(3'h1, 2'h1, ~c);
      wait_q();
      q.push_back({2'h2, c});
      u_host.gcall(1'b0);
      wait_q();
      $display("test nv_write done");
      q.push_back({`DNC_FACTORY_PD, `DNC_FACTORY_CODE});
      @(negedge clk);
      nrst = 0;
      repeat (16) @(negedge clk);
      nrst = 1;
      wait_q();
      `CHK("nv_reset", `DNC_FACTORY_CODE, nvcode)
      `CHK("drops", 0, n_drop)
      $display("test reinit done");
      wrap_up();
   end
endmodule
